// ### xrcp_pkg.sv
// package of constants and types for the transceiver management ports
package xrcp_pkg;
  localparam int XRCP_ADDR_W = 10;
  localparam int XRCP_DATA_W = 32;
  localparam int XRCP_PAR_TO_W = 70;
  localparam int XRCP_PAR_FROM_W = 46;
  localparam int XRCP_CAL_CYCLES = 16;
  localparam int XRCP_PATH_RST_CYCLES = 8;
  localparam int XRCP_BUSY_CYCLES = 2;
  localparam logic [31:0] XRCP_RESET_DATA = 32'h00000000;
  // controller register offsets (byte addresses on the software bus)
  localparam logic [3:0] XRCP_OFS_CMD = 4'h0;
  localparam logic [3:0] XRCP_OFS_ADDR = 4'h4;
  localparam logic [3:0] XRCP_OFS_WDATA = 4'h8;
  localparam logic [3:0] XRCP_OFS_RDATA = 4'hc;
  localparam int XRCP_CMD_WR_BIT = 0;
  localparam int XRCP_CMD_RD_BIT = 1;
  localparam int XRCP_CMD_RST_BIT = 2;
  localparam int XRCP_ST_BUSY_BIT = 0;
  localparam int XRCP_ST_TXDONE_BIT = 1;
  localparam int XRCP_ST_RXDONE_BIT = 2;
  localparam int XRCP_ST_TXCAL_BIT = 3;
  localparam int XRCP_ST_RXCAL_BIT = 4;
  typedef enum logic [1:0] {XRCP_IDLE, XRCP_WAIT, XRCP_DONE} xrcp_host_e;
endpackage

// ### xrcp_if.sv
// interface joining the transceiver end and the controller end
`timescale 1ns/1ps
interface xrcp_if;
  logic cfgRst;
  logic write;
  logic read;
  logic [9:0] address;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic [69:0] ctrlToPhyBus;
  logic [45:0] phyToCtrlBus;
  logic txAnalogRst;
  logic txDigitalRst;
  logic rxAnalogRst;
  logic rxDigitalRst;
  logic txCalBusy;
  logic rxCalBusy;
  logic txRstReady;
  logic rxRstReady;
  modport dev (input cfgRst, write, read, address, writedata, ctrlToPhyBus,
    txAnalogRst, txDigitalRst, rxAnalogRst, rxDigitalRst, txRstReady,
    rxRstReady, output readdata, waitrequest, phyToCtrlBus, txCalBusy,
    rxCalBusy);
  modport ctl (output cfgRst, write, read, address, writedata, ctrlToPhyBus,
    txAnalogRst, txDigitalRst, rxAnalogRst, rxDigitalRst, txRstReady,
    rxRstReady, input readdata, waitrequest, phyToCtrlBus, txCalBusy,
    rxCalBusy);
endinterface

// ### xrcp_path_reset.sv
// one path: calibration busy, then internal reset after ready
`timescale 1ns/1ps
module xrcp_path_reset (
  // clock and resets
  input wire logic clk,
  input wire logic arst,
  input wire logic analogRst,
  input wire logic digitalRst,
  // handshake
  input wire logic rstReady,
  output logic calBusy,
  output logic rstDone
);
  import xrcp_pkg::*;
  logic [7:0] calCnt_reg;
  logic [7:0] rstCnt_reg;
  logic readyQ_reg;
  logic inRst_reg;

  // calibration runs after reset and after each analog reset
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      calCnt_reg <= 8'h00;
      calBusy <= 1'b1;
    end else if (analogRst) begin
      calCnt_reg <= 8'h00;
      calBusy <= 1'b1;
    end else if (calCnt_reg < 8'(XRCP_CAL_CYCLES)) begin
      calCnt_reg <= calCnt_reg + 8'h01;
      calBusy <= 1'b1; // [R13] [R14]
    end else begin
      calBusy <= 1'b0;
    end
  end

  // rising ready starts the internal path reset
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      readyQ_reg <= 1'b0;
      inRst_reg <= 1'b0;
      rstCnt_reg <= 8'h00;
      rstDone <= 1'b0;
    end else begin
      readyQ_reg <= rstReady;
      if (digitalRst || !rstReady) begin
        inRst_reg <= 1'b0;
        rstDone <= 1'b0;
      end else if (rstReady && !readyQ_reg) begin
        inRst_reg <= 1'b1; // [R15] [R16]
        rstCnt_reg <= 8'h00;
        rstDone <= 1'b0;
      end else if (inRst_reg) begin
        rstCnt_reg <= rstCnt_reg + 8'h01;
        if (rstCnt_reg == 8'(XRCP_PATH_RST_CYCLES - 1)) begin
          inRst_reg <= 1'b0;
          rstDone <= 1'b1; // [R17]
        end
      end
    end
  end
endmodule

// ### xrcp_dev.sv
// transceiver end: reconfiguration slave and reset handshake
// Notes on behaviour
// [R1] parallel port only with negotiation or start-up
// [R2] all port signals on reconfiguration clock
// [R3] reconfiguration reset asynchronous, active high
// [R4] seventy bits in, forty-six bits back
// [R5] mapped port only when a feature enables it
// [R6] hard registers reached only through this port
// [R7] reset clears port logic and its registers
// [R8] master raises write to request a write
// [R9] master raises read to request a read
// [R10] ten-bit address, thirty-two-bit data both ways
// [R11] waitrequest high while busy; master waits
// [R12] controller drives analog and digital resets
// [R13] transmit calibration busy while calibrating
// [R14] receive calibration busy while calibrating
// [R15] transmit ready starts internal transmit reset
// [R16] receive ready starts internal receive reset
// [R17] reset done outputs after path reset
// [R18] master holds request until waitrequest falls
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module xrcp_dev #(
  parameter bit OLD_FAMILY = 1'b0,
  parameter bit EN_AUTONEG = 1'b1,
  parameter bit EN_STARTUP = 1'b0,
  parameter bit EN_DEBUG = 1'b0,
  parameter bit EN_DELAYCAL = 1'b0,
  parameter int DEPTH = 1024
) (
  // reconfiguration clock
  input wire logic clkReconfig,
  // link to controller
  xrcp_if.dev port,
  // core side
  output logic txRstDone,
  output logic rxRstDone
);
  import xrcp_pkg::*;
  localparam bit PAR_EN = OLD_FAMILY && (EN_AUTONEG || EN_STARTUP);
  localparam bit MM_EN = !OLD_FAMILY &&
    (EN_AUTONEG || EN_STARTUP || EN_DEBUG || EN_DELAYCAL);
  // hard register space; only this port reaches it
  logic [31:0] regs [DEPTH]; // [R6]
  logic [1:0] busyCnt_reg;
  logic pending_reg;
  logic pendWr_reg;
  logic [9:0] pendAddr_reg;
  logic [31:0] pendData_reg;
  logic [69:0] parCfg_reg;
  logic [45:0] parStat_reg;
  logic txCal;
  logic rxCal;
  logic txDone;
  logic rxDone;

  // accepted command: a fixed busy window, then waitrequest drops
  always_ff @(posedge clkReconfig or posedge port.cfgRst) begin // [R2] [R3]
    if (port.cfgRst) begin
      pending_reg <= 1'b0;
      pendWr_reg <= 1'b0;
      pendAddr_reg <= 10'h000;
      pendData_reg <= 32'h00000000;
      busyCnt_reg <= 2'h0;
      port.waitrequest <= 1'b1; // [R7]
      port.readdata <= XRCP_RESET_DATA;
    end else if (!MM_EN) begin
      port.waitrequest <= 1'b1; // [R5]
      port.readdata <= 32'h00000000;
    end else if (!pending_reg) begin
      port.waitrequest <= 1'b1;
      if (port.write || port.read) begin // [R8] [R9]
        pending_reg <= 1'b1;
        pendWr_reg <= port.write;
        pendAddr_reg <= port.address; // [R10]
        pendData_reg <= port.writedata;
        busyCnt_reg <= 2'h0;
      end
    end else if (busyCnt_reg != 2'(XRCP_BUSY_CYCLES - 1)) begin
      busyCnt_reg <= busyCnt_reg + 2'h1;
      port.waitrequest <= 1'b1; // [R11]
    end else if (port.waitrequest) begin
      port.waitrequest <= 1'b0;
      if (!pendWr_reg) begin
        port.readdata <= regs[pendAddr_reg];
      end
    end else begin
      // the master saw waitrequest low at this edge; the command ends
      pending_reg <= 1'b0;
      port.waitrequest <= 1'b1;
    end
  end

  // write takes effect at the edge where waitrequest is seen low
  always_ff @(posedge clkReconfig or posedge port.cfgRst) begin
    if (port.cfgRst) begin
      for (int i = 0; i < DEPTH; i++) begin
        regs[i] <= 32'h00000000; // [R7]
      end
    end else if (pending_reg && pendWr_reg && !port.waitrequest) begin
      regs[pendAddr_reg] <= pendData_reg;
    end
  end

  // legacy parallel bus: status is the configuration XORed with register zero
  always_ff @(posedge clkReconfig or posedge port.cfgRst) begin
    if (port.cfgRst) begin
      parCfg_reg <= 70'h0;
      parStat_reg <= 46'h0;
      port.phyToCtrlBus <= 46'h0;
    end else if (PAR_EN) begin // [R1]
      parCfg_reg <= port.ctrlToPhyBus; // [R4]
      parStat_reg <= parCfg_reg[45:0] ^ {14'h0, regs[0]};
      port.phyToCtrlBus <= parStat_reg;
    end else begin
      port.phyToCtrlBus <= 46'h0;
    end
  end

  xrcp_path_reset txPath (
    .clk(clkReconfig),
    .arst(port.cfgRst),
    .analogRst(port.txAnalogRst), // [R12]
    .digitalRst(port.txDigitalRst),
    .rstReady(port.txRstReady),
    .calBusy(txCal),
    .rstDone(txDone)
  );

  xrcp_path_reset rxPath (
    .clk(clkReconfig),
    .arst(port.cfgRst),
    .analogRst(port.rxAnalogRst),
    .digitalRst(port.rxDigitalRst),
    .rstReady(port.rxRstReady),
    .calBusy(rxCal),
    .rstDone(rxDone)
  );

  always_ff @(posedge clkReconfig or posedge port.cfgRst) begin
    if (port.cfgRst) begin
      port.txCalBusy <= 1'b1;
      port.rxCalBusy <= 1'b1;
      txRstDone <= 1'b0;
      rxRstDone <= 1'b0;
    end else begin
      port.txCalBusy <= txCal; // [R13]
      port.rxCalBusy <= rxCal; // [R14]
      txRstDone <= txDone; // [R17]
      rxRstDone <= rxDone;
    end
  end
endmodule

// ### xrcp_ctl.sv
// controller end: software registers drive the link master and resets
`timescale 1ns/1ps
module xrcp_ctl (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // software bus
  input wire logic [3:0] avmAddress,
  input wire logic avmRead,
  input wire logic avmWrite,
  input wire logic [31:0] avmWritedata,
  output logic [31:0] avmReaddata,
  output logic avmWaitrequest,
  // link to transceiver end
  xrcp_if.ctl port
);
  import xrcp_pkg::*;
  xrcp_host_e state_reg;
  logic [9:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic isWr_reg;
  logic [3:0] rstCtl_reg;
  logic [2:0] wr1, wr2, wr3;

  // bus slave answers in one wait cycle; a read/write cmd while busy is ignored, but its reset bit still takes effect
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avmWaitrequest <= 1'b1;
      avmReaddata <= 32'h00000000;
    end else if ((avmRead || avmWrite) && avmWaitrequest) begin
      avmWaitrequest <= 1'b0;
      unique case (avmAddress)
        XRCP_OFS_CMD: avmReaddata <= {27'h0, wr3[0], wr3[1],
          port.txCalBusy, port.rxCalBusy, state_reg != XRCP_IDLE};
        XRCP_OFS_ADDR: avmReaddata <= {22'h0, addr_reg};
        XRCP_OFS_WDATA: avmReaddata <= wdata_reg;
        XRCP_OFS_RDATA: avmReaddata <= rdata_reg;
        default: avmReaddata <= 32'h00000000;
      endcase
    end else begin
      avmWaitrequest <= 1'b1;
    end
  end

  wire swWr = avmWrite && !avmWaitrequest;

  // calibration busy flags come from the reconfiguration domain: three flops
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr1 <= 3'h0;
      wr2 <= 3'h0;
      wr3 <= 3'h0;
    end else begin
      wr1 <= {1'b0, port.rxCalBusy, port.txCalBusy};
      wr2 <= wr1;
      if (wr2 == wr1) wr3 <= wr2;
    end
  end

  // master holds request until it sees waitrequest low
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= XRCP_IDLE;
      port.write <= 1'b0;
      port.read <= 1'b0;
      port.address <= 10'h000;
      port.writedata <= 32'h00000000;
      addr_reg <= 10'h000;
      wdata_reg <= 32'h00000000;
      rdata_reg <= 32'h00000000;
      isWr_reg <= 1'b0;
    end else begin
      if (swWr && avmAddress == XRCP_OFS_ADDR) addr_reg <= avmWritedata[9:0];
      if (swWr && avmAddress == XRCP_OFS_WDATA) wdata_reg <= avmWritedata;
      unique case (state_reg)
        XRCP_IDLE: begin
          if (swWr && avmAddress == XRCP_OFS_CMD &&
              (avmWritedata[XRCP_CMD_WR_BIT] ||
               avmWritedata[XRCP_CMD_RD_BIT])) begin
            isWr_reg <= avmWritedata[XRCP_CMD_WR_BIT];
            port.write <= avmWritedata[XRCP_CMD_WR_BIT]; // [R8]
            port.read <= !avmWritedata[XRCP_CMD_WR_BIT]; // [R9]
            port.address <= addr_reg; // [R10]
            port.writedata <= wdata_reg;
            state_reg <= XRCP_WAIT;
          end
        end
        XRCP_WAIT: begin
          // clock crossing is left to the integrator: one shared clock
          if (!port.waitrequest) begin // [R11] [R18]
            port.write <= 1'b0;
            port.read <= 1'b0;
            if (!isWr_reg) rdata_reg <= port.readdata;
            state_reg <= XRCP_DONE;
          end
        end
        XRCP_DONE: state_reg <= XRCP_IDLE;
      endcase
    end
  end

  // reset controller: the software reset bit drives analog/digital and ready; calibration busy also holds digital and ready
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rstCtl_reg <= 4'hf;
      port.cfgRst <= 1'b1;
      port.txAnalogRst <= 1'b1;
      port.txDigitalRst <= 1'b1;
      port.rxAnalogRst <= 1'b1;
      port.rxDigitalRst <= 1'b1;
      port.txRstReady <= 1'b0;
      port.rxRstReady <= 1'b0;
      port.ctrlToPhyBus <= 70'h0;
    end else begin
      if (swWr && avmAddress == XRCP_OFS_CMD) begin
        rstCtl_reg <= {3'h0, avmWritedata[XRCP_CMD_RST_BIT]};
      end
      port.cfgRst <= rstCtl_reg[0];
      port.txAnalogRst <= rstCtl_reg[0]; // [R12]
      port.rxAnalogRst <= rstCtl_reg[0];
      port.txDigitalRst <= rstCtl_reg[0] || wr3[0];
      port.rxDigitalRst <= rstCtl_reg[0] || wr3[1];
      port.txRstReady <= !rstCtl_reg[0] && !wr3[0];
      port.rxRstReady <= !rstCtl_reg[0] && !wr3[1];
      // follows the issued write data, one cycle behind it
      port.ctrlToPhyBus <= {38'h0, port.writedata}; // [R4]
    end
  end
endmodule

// ### xrcp_sva.sv
// concurrent checks on the link between controller and transceiver end
`timescale 1ns/1ps
module xrcp_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // link
  input wire logic cfgRst,
  input wire logic write,
  input wire logic read,
  input wire logic [9:0] address,
  input wire logic [31:0] writedata,
  input wire logic waitrequest,
  input wire logic [69:0] ctrlToPhyBus,
  input wire logic [45:0] phyToCtrlBus,
  input wire logic txAnalogRst,
  input wire logic txCalBusy,
  input wire logic rxCalBusy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_rst_holds_wait: assert property (cfgRst |-> waitrequest)
    else $error("waitrequest low in link reset");
  a_cal_in_rst: assert property (cfgRst |-> txCalBusy && rxCalBusy)
    else $error("calibration busy low in link reset");
  a_no_dual_req: assert property (!(write && read))
    else $error("read and write together");
  // a request must not move while the slave is still busy with it
  a_req_hold: assert property (disable iff (srst || cfgRst)
    (write || read) && waitrequest |=> $stable(address)
    && $stable(writedata) && $stable(write) && $stable(read))
    else $error("request changed under waitrequest");
  a_wait_latency: assert property (disable iff (srst || cfgRst)
    $rose(write || read) |=> waitrequest [*2] ##1 !waitrequest)
    else $error("answer latency wrong");
  a_release_after: assert property (disable iff (srst || cfgRst)
    (write || read) && !waitrequest |=> !write && !read)
    else $error("request not released after answer");
  a_ctrl_bus: assert property (ctrlToPhyBus == {38'h0, $past(writedata)})
    else $error("parallel bus does not follow write data");
  // newer family build: the parallel return bus carries nothing
  a_phy_quiet: assert property (phyToCtrlBus == 46'h0)
    else $error("parallel return bus active");
  a_cal_ends: assert property (disable iff (srst || cfgRst)
    $fell(txAnalogRst) |-> ##[1:40] !txCalBusy)
    else $error("transmit calibration never ends");
endmodule

// ### tb_xcvr_reconfig_and_reset_ports.sv
// testbench: software bus drives the controller, which drives the far end
`timescale 1ns/1ps
module tb_xcvr_reconfig_and_reset_ports;
  import xrcp_pkg::*;
  logic clk_sys;
  logic srst;
  logic [3:0] avmAddress;
  logic avmRead;
  logic avmWrite;
  logic [31:0] avmWritedata;
  logic [31:0] avmReaddata;
  logic avmWaitrequest;
  logic txRstDone;
  logic rxRstDone;
  logic [31:0] rd;
  logic [9:0] ad [4] = '{10'h000, 10'h001, 10'h155, 10'h3ff};
  logic [31:0] dt [4] = '{32'ha5a5_0001, 32'h0000_0002, 32'hffff_ffff,
    32'h8000_0001};
  int fails = 0;
  int nChecks = 0;
  int cyc = 0;
  xrcp_if link ();
  xrcp_ctl i_xrcp_ctl (.clk_sys(clk_sys), .srst(srst),
    .avmAddress(avmAddress), .avmRead(avmRead), .avmWrite(avmWrite),
    .avmWritedata(avmWritedata), .avmReaddata(avmReaddata),
    .avmWaitrequest(avmWaitrequest), .port(link.ctl));
  // both ends share one clock, so no crossing is modelled here
  xrcp_dev i_xrcp_dev (.clkReconfig(clk_sys), .port(link.dev),
    .txRstDone(txRstDone), .rxRstDone(rxRstDone));
  xrcp_sva i_xrcp_sva (.clk_sys(clk_sys), .srst(srst),
    .cfgRst(link.cfgRst), .write(link.write), .read(link.read),
    .address(link.address), .writedata(link.writedata),
    .waitrequest(link.waitrequest), .ctrlToPhyBus(link.ctrlToPhyBus),
    .phyToCtrlBus(link.phyToCtrlBus), .txAnalogRst(link.txAnalogRst),
    .txCalBusy(link.txCalBusy), .rxCalBusy(link.rxCalBusy));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // generous ceiling: the whole run needs a few hundred cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [3:0] a, input logic wr,
    input logic [31:0] d);
    @(posedge clk_sys);
    avmAddress <= a;
    avmWrite <= wr;
    avmRead <= !wr;
    avmWritedata <= d;
    @(posedge clk_sys);
    while (avmWaitrequest !== 1'b0) @(posedge clk_sys);
    rd = avmReaddata;
    avmWrite <= 1'b0;
    avmRead <= 1'b0;
  endtask
  task automatic idle();
    int i;
    i = 0;
    do begin
      acc(XRCP_OFS_CMD, 1'b0, 32'h0);
      i++;
    end while (rd[XRCP_ST_BUSY_BIT] !== 1'b0 && i < 60);
  endtask
  task automatic lw(input logic [9:0] a, input logic [31:0] d);
    acc(XRCP_OFS_ADDR, 1'b1, {22'h0, a});
    acc(XRCP_OFS_WDATA, 1'b1, d);
    acc(XRCP_OFS_CMD, 1'b1, 32'h1);
    idle();
  endtask
  task automatic lr(input logic [9:0] a);
    acc(XRCP_OFS_ADDR, 1'b1, {22'h0, a});
    acc(XRCP_OFS_CMD, 1'b1, 32'h2);
    idle();
    acc(XRCP_OFS_RDATA, 1'b0, 32'h0);
  endtask
  task automatic bringUp();
    acc(XRCP_OFS_CMD, 1'b1, 32'h0);
    wait (link.txRstReady === 1'b1 && link.rxRstReady === 1'b1);
    // ready edge, eight counting edges, then the output flop
    repeat (XRCP_PATH_RST_CYCLES + 3) @(posedge clk_sys);
    chk({30'h0, txRstDone, rxRstDone}, 32'h3);
    repeat (XRCP_CAL_CYCLES + 4) @(posedge clk_sys);
    chk({30'h0, link.txCalBusy, link.rxCalBusy}, 32'h0);
  endtask
  initial begin
    srst = 1'b1;
    avmAddress = 4'h0;
    avmRead = 1'b0;
    avmWrite = 1'b0;
    avmWritedata = 32'h0;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    chk({28'h0, link.cfgRst, link.txAnalogRst, link.txRstReady,
      txRstDone}, 32'hc);
    acc(4'h1, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bringUp();
    for (int i = 0; i < 4; i++) lw(ad[i], dt[i]);
    for (int i = 0; i < 4; i++) begin
      lr(ad[i]);
      chk(rd, dt[i]);
    end
    lr(10'h2aa);
    chk(rd, XRCP_RESET_DATA);
    // reset the far end in mid-run: its registers must clear
    acc(XRCP_OFS_CMD, 1'b1, 32'h4);
    repeat (3) @(posedge clk_sys);
    chk({30'h0, link.cfgRst, txRstDone}, 32'h2);
    bringUp();
    lr(ad[2]);
    chk(rd, XRCP_RESET_DATA);
    summarize();
  end
endmodule
